// File: logic/addr_timing.sv
// operand address decode and instruction timing for the core
// How it works
// - direct 0x80-0xff goes to special function registers
// - indirect 0x80-0xff goes to upper internal ram
// - 0x00-0x7f is internal ram in both modes
// - 256-byte extended ram, extended moves only
// - extended direct address from data pointer
// - extended indirect address from pointer register
// - both extended modes reach all extended ram
// - code read address is acc plus data pointer
// - immediate operand is literal from instruction bytes
// - indirect address comes from pointer register at run
// - add family: register 1/1, others 2 cycles
// - logic dir,#imm 3/3; dir,acc 2 cycles
// - xor register 1/1, indirect 2/2
// - add with carry direct/immediate 2/2
// - most instructions one or two cycles
// - register operands are the fastest mode
// - extended ram enabled only when cfg is 01
`timescale 1ns/1ps
`default_nettype none
module addr_timing (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // decode request
  input wire logic i_req,
  input wire addr_timing_pkg::op_type i_op,
  input wire addr_timing_pkg::mode_type i_mode,
  input wire logic [7:0] i_operand,
  input wire logic [2:0] i_reg_sel,
  // core state
  input wire logic [7:0] i_acc,
  input wire logic [15:0] i_data_pointer,
  input wire logic [1:0] i_bank_sel,
  input wire logic [7:0] i_pointer_value,
  input wire logic [1:0] i_cfg,
  // decode answer
  output logic o_done,
  output addr_timing_pkg::space_type o_space,
  output logic [15:0] o_addr,
  output logic [7:0] o_literal,
  output logic [3:0] o_bytes,
  output logic [3:0] o_cycles,
  output logic o_illegal,
  output logic o_busy
);
  import addr_timing_pkg::*;

  state_type state_r;
  logic [3:0] count_r;
  space_type space_nxt;
  logic [15:0] addr_nxt;
  logic [3:0] bytes_nxt;
  logic [3:0] cycles_nxt;
  logic illegal_nxt;
  logic ext_en;

  // bank register address in the low region of internal ram
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] r);
    bank_addr = {3'h0, bank, r};
  endfunction

  // routing of an 8-bit data address by mode
  function automatic space_type data_space(input logic indirect, input logic [7:0] a);
    if (a <= RAM_LOW_TOP) begin
      data_space = SPACE_RAM;
    end else if (indirect) begin
      data_space = SPACE_RAM;
    end else begin
      data_space = SPACE_SPECIAL_FUNCTION_REGISTER;
    end
  endfunction

  assign ext_en = (i_cfg == EXT_RAM_ENABLE_CODE);

  always_comb begin
    space_nxt = SPACE_NONE;
    addr_nxt = 16'h0000;
    illegal_nxt = 1'b0;
    unique case (i_mode)
      MODE_BANK_REG: begin
        space_nxt = SPACE_RAM;
        addr_nxt = {8'h00, bank_addr(i_bank_sel, i_reg_sel)};
      end
      MODE_DIRECT: begin
        space_nxt = data_space(1'b0, i_operand);
        addr_nxt = {8'h00, i_operand};
      end
      MODE_INDIRECT: begin
        space_nxt = data_space(1'b1, i_pointer_value);
        addr_nxt = {8'h00, i_pointer_value};
      end
      MODE_IMMEDIATE: begin
        space_nxt = SPACE_LITERAL;
      end
      MODE_EXT_DIRECT: begin
        space_nxt = ext_en ? SPACE_EXT_RAM : SPACE_NONE;
        illegal_nxt = !ext_en;
        // only the low byte reaches the 256-byte array
        addr_nxt = {8'h00, i_data_pointer[7:0]};
      end
      MODE_EXT_INDIRECT: begin
        space_nxt = ext_en ? SPACE_EXT_RAM : SPACE_NONE;
        illegal_nxt = !ext_en;
        addr_nxt = {8'h00, i_pointer_value};
      end
      MODE_CODE_INDIRECT: begin
        space_nxt = SPACE_CODE;
        addr_nxt = 16'(i_data_pointer + {8'h00, i_acc});
      end
      MODE_ACC_ONLY: begin
        space_nxt = SPACE_NONE;
      end
    endcase
  end

  // byte length and cycle count
  always_comb begin
    bytes_nxt = LEN_TWO;
    cycles_nxt = CYC_TWO;
    unique case (i_op)
      OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
      OP_LOGIC_AND, OP_LOGIC_OR, OP_LOGIC_EXCLUSIVE_OR: begin
        if (i_mode == MODE_BANK_REG) begin
          bytes_nxt = LEN_ONE;
          cycles_nxt = CYC_ONE;
        end else if (i_mode == MODE_INDIRECT && i_op != OP_LOGIC_EXCLUSIVE_OR) begin
          bytes_nxt = LEN_ONE;
          cycles_nxt = CYC_TWO;
        end else begin
          bytes_nxt = LEN_TWO;
          cycles_nxt = CYC_TWO;
        end
      end
      OP_LOGIC_DIR_ACC: begin
        bytes_nxt = LEN_TWO;
        cycles_nxt = CYC_TWO;
      end
      OP_LOGIC_DIR_IMM: begin
        bytes_nxt = LEN_THREE;
        cycles_nxt = CYC_THREE;
      end
      OP_ACC_UNARY: begin
        bytes_nxt = LEN_ONE;
        cycles_nxt = CYC_ONE;
      end
      OP_MULTIPLY_ACC_B, OP_DIVIDE_ACC_B: begin
        bytes_nxt = LEN_ONE;
        cycles_nxt = CYC_NINE;
      end
      OP_EXT_RAM_MOVE, OP_CODE_BYTE_MOVE: begin
        bytes_nxt = LEN_ONE;
        cycles_nxt = CYC_FOUR;
      end
      default: begin
        bytes_nxt = LEN_ONE;
        cycles_nxt = CYC_ONE;
      end
    endcase
  end

  // sequencer: busy is held for one cycle less than the instruction's cycle count, then done pulses
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      count_r <= 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (i_req) begin
            state_r <= (cycles_nxt == CYC_ONE) ? ST_DONE : ST_BUSY;
            count_r <= 4'(cycles_nxt - 4'h1);
          end
        end
        ST_BUSY: begin
          count_r <= 4'(count_r - 4'h1);
          if (count_r == 4'h1) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // decoded results captured at the request
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_space <= SPACE_NONE;
      o_addr <= 16'h0000;
      o_literal <= 8'h00;
      o_bytes <= 4'h0;
      o_cycles <= 4'h0;
      o_illegal <= 1'b0;
    end else if (state_r == ST_IDLE && i_req) begin
      o_space <= space_nxt;
      o_addr <= addr_nxt;
      o_literal <= (i_mode == MODE_IMMEDIATE) ? i_operand : 8'h00;
      o_bytes <= bytes_nxt;
      o_cycles <= cycles_nxt;
      o_illegal <= illegal_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_done <= (state_r == ST_IDLE && i_req && cycles_nxt == CYC_ONE)
        || (state_r == ST_BUSY && count_r == 4'h1);
      o_busy <= (state_r == ST_IDLE && i_req && cycles_nxt != CYC_ONE)
        || (state_r == ST_BUSY && count_r != 4'h1);
    end
  end

  // checks
  property p_direct_special;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_DIRECT && i_operand[7])
      |=> o_space == SPACE_SPECIAL_FUNCTION_REGISTER;
  endproperty
  a_direct_special: assert property (p_direct_special)
    else $error("direct high not special register");

  property p_indirect_ram;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_INDIRECT)
      |=> o_space == SPACE_RAM && o_addr[7:0] == $past(i_pointer_value);
  endproperty
  a_indirect_ram: assert property (p_indirect_ram) else $error("indirect not ram");

  property p_low_ram;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_DIRECT && !i_operand[7])
      |=> o_space == SPACE_RAM;
  endproperty
  a_low_ram: assert property (p_low_ram) else $error("low direct not ram");

  property p_ext_gate;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_EXT_INDIRECT && i_cfg != 2'h1)
      |=> o_illegal && o_space == SPACE_NONE;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("ext ram used while off");

  property p_ext_dp;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_EXT_DIRECT)
      |=> o_addr == {8'h00, $past(i_data_pointer[7:0])};
  endproperty
  a_ext_dp: assert property (p_ext_dp) else $error("ext direct addr wrong");

  property p_code_addr;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_CODE_INDIRECT)
      |=> o_addr == 16'($past(i_data_pointer) + {8'h00, $past(i_acc)});
  endproperty
  a_code_addr: assert property (p_code_addr) else $error("code addr wrong");

  property p_reg_one;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_BANK_REG && i_op == OP_ADD)
      |=> o_done && o_cycles == 4'h1 && o_bytes == 4'h1;
  endproperty
  a_reg_one: assert property (p_reg_one) else $error("register op not 1 cycle");

  property p_dir_imm;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_op == OP_LOGIC_DIR_IMM)
      |=> !o_done [*2] ##1 o_done && o_bytes == 4'h3;
  endproperty
  a_dir_imm: assert property (p_dir_imm) else $error("dir imm timing wrong");

  property p_xor_ind;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_op == OP_LOGIC_EXCLUSIVE_OR && i_mode == MODE_INDIRECT)
      |=> !o_done ##1 o_done && o_bytes == 4'h2;
  endproperty
  a_xor_ind: assert property (p_xor_ind) else $error("xor indirect timing wrong");

  property p_bank;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_BANK_REG)
      |=> o_addr == {11'h000, $past(i_bank_sel), $past(i_reg_sel)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank addr wrong");

  property p_ext_ind;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_EXT_INDIRECT
        && i_cfg == EXT_RAM_ENABLE_CODE)
      |=> o_space == SPACE_EXT_RAM && o_addr == {8'h00, $past(i_pointer_value)};
  endproperty
  a_ext_ind: assert property (p_ext_ind) else $error("ext indirect addr wrong");

  property p_ext_on;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_EXT_DIRECT
        && i_cfg == EXT_RAM_ENABLE_CODE)
      |=> o_space == SPACE_EXT_RAM && !o_illegal;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("ext ram not reached");

  property p_imm;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_IMMEDIATE)
      |=> o_space == SPACE_LITERAL && o_literal == $past(i_operand);
  endproperty
  a_imm: assert property (p_imm) else $error("literal not taken");

  property p_unary;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_op == OP_ACC_UNARY)
      |=> o_done && o_cycles == 4'h1 && o_bytes == 4'h1;
  endproperty
  a_unary: assert property (p_unary) else $error("unary op not 1 cycle");

  property p_dir_acc;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_op == OP_LOGIC_DIR_ACC)
      |=> !o_done ##1 o_done && o_bytes == 4'h2;
  endproperty
  a_dir_acc: assert property (p_dir_acc) else $error("dir acc timing wrong");

  property p_add_ind;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_mode == MODE_INDIRECT
        && (i_op == OP_ADD || i_op == OP_ADD_WITH_CARRY || i_op == OP_SUBTRACT_WITH_BORROW))
      |=> !o_done ##1 o_done && o_bytes == 4'h1 && o_cycles == 4'h2;
  endproperty
  a_add_ind: assert property (p_add_ind) else $error("add indirect timing wrong");

  property p_add_with_carry_dir;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == ST_IDLE && i_req && i_op == OP_ADD_WITH_CARRY
        && (i_mode == MODE_DIRECT || i_mode == MODE_IMMEDIATE))
      |=> !o_done ##1 o_done && o_bytes == 4'h2 && o_cycles == 4'h2;
  endproperty
  a_add_with_carry_dir: assert property (p_add_with_carry_dir) else $error("carry add timing wrong");

  c_special: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    o_space == SPACE_SPECIAL_FUNCTION_REGISTER);
  c_ext: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_space == SPACE_EXT_RAM);
  c_nine: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_done && o_cycles == 4'h9);
  c_code: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_space == SPACE_CODE);
  c_illegal: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_illegal);
endmodule
`default_nettype wire

// File: logic/addr_timing_pkg.sv
// constants and types for the operand addressing and timing decoder
package addr_timing_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [7:0] SPECIAL_FUNCTION_REGISTER_LOW = 8'h80;
  localparam logic [7:0] RAM_LOW_TOP = 8'h7f;
  localparam int unsigned EXT_RAM_DEPTH = 256;
  localparam logic [1:0] EXT_RAM_ENABLE_CODE = 2'h1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_THREE = 4'h3;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;
  localparam logic [3:0] CYC_NINE = 4'h9;

  // operand addressing mode
  typedef enum logic [2:0] {
    MODE_BANK_REG = 3'h0,
    MODE_DIRECT = 3'h1,
    MODE_INDIRECT = 3'h2,
    MODE_IMMEDIATE = 3'h3,
    MODE_EXT_DIRECT = 3'h4,
    MODE_EXT_INDIRECT = 3'h5,
    MODE_CODE_INDIRECT = 3'h6,
    MODE_ACC_ONLY = 3'h7
  } mode_type;

  // instruction class for timing
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADD_WITH_CARRY = 4'h1,
    OP_SUBTRACT_WITH_BORROW = 4'h2,
    OP_LOGIC_AND = 4'h3,
    OP_LOGIC_OR = 4'h4,
    OP_LOGIC_EXCLUSIVE_OR = 4'h5,
    OP_LOGIC_DIR_ACC = 4'h6,
    OP_LOGIC_DIR_IMM = 4'h7,
    OP_ACC_UNARY = 4'h8,
    OP_MULTIPLY_ACC_B = 4'h9,
    OP_DIVIDE_ACC_B = 4'ha,
    OP_EXT_RAM_MOVE = 4'hb,
    OP_CODE_BYTE_MOVE = 4'hc
  } op_type;

  // operand target space
  typedef enum logic [2:0] {
    SPACE_NONE = 3'h0,
    SPACE_RAM = 3'h1,
    SPACE_SPECIAL_FUNCTION_REGISTER = 3'h3,
    SPACE_EXT_RAM = 3'h2,
    SPACE_CODE = 3'h6,
    SPACE_LITERAL = 3'h7
  } space_type;

  // decode state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } state_type;
endpackage

// File: testbench/addr_timing_tb.sv
// self-checking testbench for the operand decode and timing block
`timescale 1ns/1ps
`default_nettype none
module addr_timing_tb;
  import addr_timing_pkg::*;
  logic i_clk, i_rst_b, i_req;
  op_type i_op;
  mode_type i_mode;
  logic [7:0] i_operand, i_acc, i_pointer_value;
  logic [2:0] i_reg_sel;
  logic [15:0] i_data_pointer;
  logic [1:0] i_bank_sel, i_cfg;
  logic o_done, o_illegal, o_busy;
  space_type o_space;
  logic [15:0] o_addr;
  logic [7:0] o_literal, rd_data;
  logic [3:0] o_bytes, o_cycles;
  int err_count = 0;
  int num_checks = 0;

  addr_timing uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_op(i_op),
    .i_mode(i_mode), .i_operand(i_operand), .i_reg_sel(i_reg_sel), .i_acc(i_acc),
    .i_data_pointer(i_data_pointer), .i_bank_sel(i_bank_sel),
    .i_pointer_value(i_pointer_value), .i_cfg(i_cfg), .o_done(o_done), .o_space(o_space),
    .o_addr(o_addr), .o_literal(o_literal), .o_bytes(o_bytes), .o_cycles(o_cycles),
    .o_illegal(o_illegal), .o_busy(o_busy));
  onchip_mem_model mem (.i_space(o_space), .i_addr(o_addr), .o_rd_data(rd_data));

  initial begin
    i_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one request, wait for done, then judge timing, busy, bytes, cycles and the space, address, literal and illegal fields the mode uses
  task automatic xact(input op_type o, input mode_type m, input logic [7:0] opd,
                      input space_type sp, input logic [15:0] ad, input logic [3:0] nb,
                      input logic [3:0] nc);
    int n;
    logic b;
    @(posedge i_clk) #1;
    i_op = o;
    i_mode = m;
    i_operand = opd;
    i_req = 1'b1;
    @(posedge i_clk) #1;
    i_req = 1'b0;
    n = 1;
    b = o_busy;
    while (o_done !== 1'b1 && n < 20) begin
      @(posedge i_clk) #1;
      n++;
    end
    chk("done_cycle", 16'(n), 16'(nc));
    chk("busy", {15'h0, b}, {15'h0, nc > CYC_ONE});
    chk("busy_at_done", {15'h0, o_busy}, 16'h0000);
    chk("bytes", {12'h0, o_bytes}, {12'h0, nb});
    chk("cycles", {12'h0, o_cycles}, {12'h0, nc});
    if (m != MODE_ACC_ONLY) begin
      chk("space", {13'h0, o_space}, {13'h0, sp});
      if (sp != SPACE_NONE && sp != SPACE_LITERAL) chk("addr", o_addr, ad);
    end
    if (m == MODE_IMMEDIATE) chk("literal", {8'h0, o_literal}, {8'h0, opd});
    if (m == MODE_EXT_DIRECT || m == MODE_EXT_INDIRECT)
      chk("illegal", {15'h0, o_illegal}, {15'h0, i_cfg != EXT_RAM_ENABLE_CODE});
    @(posedge i_clk) #1;
    chk("done_pulse", {15'h0, o_done}, 16'h0000);
  endtask

  task automatic t_direct();
    xact(OP_ADD, MODE_DIRECT, 8'h7f,
      SPACE_RAM, 16'h007f, LEN_TWO, CYC_TWO);
    xact(OP_ADD_WITH_CARRY, MODE_DIRECT, 8'h80,
      SPACE_SPECIAL_FUNCTION_REGISTER, 16'h0080, LEN_TWO, CYC_TWO);
    xact(OP_SUBTRACT_WITH_BORROW, MODE_DIRECT, 8'hff,
      SPACE_SPECIAL_FUNCTION_REGISTER, 16'h00ff, LEN_TWO, CYC_TWO);
    $display("test direct done");
  endtask

  task automatic t_indirect();
    i_pointer_value = 8'h80;
    xact(OP_ADD, MODE_INDIRECT, 8'h00,
      SPACE_RAM, 16'h0080, LEN_ONE, CYC_TWO);
    i_pointer_value = 8'hff;
    xact(OP_LOGIC_EXCLUSIVE_OR, MODE_INDIRECT, 8'h00,
      SPACE_RAM, 16'h00ff, LEN_TWO, CYC_TWO);
    i_pointer_value = 8'h00;
    xact(OP_LOGIC_AND, MODE_INDIRECT, 8'h90,
      SPACE_RAM, 16'h0000, LEN_ONE, CYC_TWO);
    i_pointer_value = 8'hc4;
    xact(OP_LOGIC_OR, MODE_INDIRECT, 8'h00,
      SPACE_RAM, 16'h00c4, LEN_ONE, CYC_TWO);
    $display("test indirect done");
  endtask

  task automatic t_bank();
    i_bank_sel = 2'h2;
    i_reg_sel = 3'h5;
    xact(OP_ADD, MODE_BANK_REG, 8'h00,
      SPACE_RAM, 16'h0015, LEN_ONE, CYC_ONE);
    xact(OP_SUBTRACT_WITH_BORROW, MODE_BANK_REG, 8'h00,
      SPACE_RAM, 16'h0015, LEN_ONE, CYC_ONE);
    i_bank_sel = 2'h3;
    i_reg_sel = 3'h7;
    xact(OP_LOGIC_EXCLUSIVE_OR, MODE_BANK_REG, 8'h00,
      SPACE_RAM, 16'h001f, LEN_ONE, CYC_ONE);
    $display("test bank done");
  endtask

  task automatic t_imm_logic();
    xact(OP_ADD_WITH_CARRY, MODE_IMMEDIATE, 8'ha8,
      SPACE_LITERAL, 16'h0, LEN_TWO, CYC_TWO);
    xact(OP_LOGIC_DIR_IMM, MODE_DIRECT, 8'h30,
      SPACE_RAM, 16'h0030, LEN_THREE, CYC_THREE);
    xact(OP_LOGIC_DIR_ACC, MODE_DIRECT, 8'h90,
      SPACE_SPECIAL_FUNCTION_REGISTER, 16'h0090, LEN_TWO, CYC_TWO);
    xact(OP_ACC_UNARY, MODE_ACC_ONLY, 8'h00,
      SPACE_NONE, 16'h0, LEN_ONE, CYC_ONE);
    xact(OP_MULTIPLY_ACC_B, MODE_ACC_ONLY, 8'h00,
      SPACE_NONE, 16'h0, LEN_ONE, CYC_NINE);
    xact(OP_DIVIDE_ACC_B, MODE_ACC_ONLY, 8'h00,
      SPACE_NONE, 16'h0, LEN_ONE, CYC_NINE);
    $display("test immediate and logic done");
  endtask

  task automatic t_ext_code();
    i_cfg = 2'h1;
    i_data_pointer = 16'h12ab;
    i_pointer_value = 8'hff;
    xact(OP_EXT_RAM_MOVE, MODE_EXT_DIRECT, 8'h00,
      SPACE_EXT_RAM, 16'h00ab, LEN_ONE, CYC_FOUR);
    chk("ext_data", {8'h0, rd_data}, 16'h0054);
    xact(OP_EXT_RAM_MOVE, MODE_EXT_INDIRECT, 8'h00,
      SPACE_EXT_RAM, 16'h00ff, LEN_ONE, CYC_FOUR);
    chk("ext_data_top", {8'h0, rd_data}, 16'h0000);
    for (int c = 0; c < 4; c += 2) begin
      i_cfg = 2'(c);
      xact(OP_EXT_RAM_MOVE, MODE_EXT_INDIRECT, 8'h00,
        SPACE_NONE, 16'h0, LEN_ONE, CYC_FOUR);
      // low bit set but upper bit set too: must stay off
      i_cfg = 2'h3;
      xact(OP_EXT_RAM_MOVE, MODE_EXT_DIRECT, 8'h00,
        SPACE_NONE, 16'h0, LEN_ONE, CYC_FOUR);
    end
    i_data_pointer = 16'h2002;
    i_acc = 8'h05;
    xact(OP_CODE_BYTE_MOVE, MODE_CODE_INDIRECT, 8'h00,
      SPACE_CODE, 16'h2007, LEN_ONE, CYC_FOUR);
    chk("code_data", {8'h0, rd_data}, 16'h0027);
    i_data_pointer = 16'hfffe;
    i_acc = 8'h03;
    xact(OP_CODE_BYTE_MOVE, MODE_CODE_INDIRECT, 8'h00,
      SPACE_CODE, 16'h0001, LEN_ONE, CYC_FOUR);
    $display("test extended and code done");
  endtask

  // a request during busy is ignored, then reset in mid-run clears everything
  task automatic t_refuse_reset();
    @(posedge i_clk) #1;
    i_op = OP_LOGIC_DIR_IMM;
    i_mode = MODE_DIRECT;
    i_operand = 8'h40;
    i_req = 1'b1;
    @(posedge i_clk) #1;
    i_op = OP_MULTIPLY_ACC_B;
    i_mode = MODE_ACC_ONLY;
    repeat (2) @(posedge i_clk);
    #1;
    i_req = 1'b0;
    chk("refused_cycles", {12'h0, o_cycles}, {12'h0, CYC_THREE});
    chk("refused_done", {15'h0, o_done}, 16'h0001);
    @(posedge i_clk) #1;
    i_op = OP_LOGIC_DIR_IMM;
    i_mode = MODE_DIRECT;
    i_req = 1'b1;
    @(posedge i_clk) #1;
    i_req = 1'b0;
    i_rst_b = 1'b0;
    @(posedge i_clk) #1;
    i_rst_b = 1'b1;
    chk("reset_busy", {15'h0, o_busy}, 16'h0);
    chk("reset_done", {15'h0, o_done}, 16'h0);
    chk("reset_bytes", {12'h0, o_bytes}, 16'h0);
    xact(OP_ADD, MODE_DIRECT, 8'h10,
      SPACE_RAM, 16'h0010, LEN_TWO, CYC_TWO);
    $display("test refuse and reset done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(CLK_PERIOD_NS * 5000);
    err_count++;
    print_verdict();
  end

  initial begin
    i_rst_b = 1'b0;
    i_req = 1'b0;
    i_op = OP_ADD;
    i_mode = MODE_DIRECT;
    i_operand = 8'h00;
    i_reg_sel = 3'h0;
    i_acc = 8'h00;
    i_data_pointer = 16'h0000;
    i_bank_sel = 2'h0;
    i_pointer_value = 8'h00;
    i_cfg = 2'h0;
    repeat (12) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    t_direct();
    t_indirect();
    t_bank();
    t_imm_logic();
    t_ext_code();
    t_refuse_reset();
    print_verdict();
  end
endmodule
`default_nettype wire

// File: testbench/onchip_mem_model.sv
// behavioural on-chip memories answering the decoded operand space and address
`timescale 1ns/1ps
`default_nettype none
module onchip_mem_model (
  // decoded access
  input wire addr_timing_pkg::space_type i_space,
  input wire logic [15:0] i_addr,
  // read data
  output logic [7:0] o_rd_data
);
  import addr_timing_pkg::*;
  always_comb begin
    case (i_space)
      SPACE_RAM: o_rd_data = i_addr[7:0] ^ 8'h3c;
      SPACE_SPECIAL_FUNCTION_REGISTER: o_rd_data = i_addr[7:0] ^ 8'hc3;
      // only 256 bytes exist; anything above reads back its upper address byte
      SPACE_EXT_RAM: begin
        o_rd_data = (i_addr[15:8] == 8'h00) ? ~i_addr[7:0] : i_addr[15:8];
      end
      // 16 kB flash, upper address bits ignored
      SPACE_CODE: o_rd_data = i_addr[7:0] ^ {2'h0, i_addr[13:8]};
      default: o_rd_data = 8'h00;
    endcase
  end
endmodule
`default_nettype wire
